// >>> rtl/ppcg_pkg.sv
// Package with register map, field positions and timing for port core clock gating
package ppcg_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CORES = 2;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_POWER_DOWN_CLOCK_CTL    = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_MISC_CLOCK_FORCE_CTL    = 8'h27;
  localparam logic [ADDR_W-1:0] OFS_TRANSLATION_DEBUG_CTL_2 = 8'h46;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_SPARE_CTL_A       = 8'he0;
  localparam logic [ADDR_W-1:0] OFS_BRANCH_STATUS           = 8'hf0;

  // Reset values: no gate bits set, no branch stopped
  localparam logic [DATA_W-1:0] RST_POWER_DOWN_CLOCK_CTL    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MISC_CLOCK_FORCE_CTL    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_TRANSLATION_DEBUG_CTL_2 = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CLOCK_SPARE_CTL_A       = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED              = 32'h0000_0000;

  // Gate bit positions, core 1 then core 2
  localparam int unsigned BIT_TX_GATE_CORE1        = 0;
  localparam int unsigned BIT_TX_GATE_CORE2        = 1;
  localparam int unsigned BIT_LINK_DYN_GATE_CORE1  = 28;
  localparam int unsigned BIT_LINK_DYN_GATE_CORE2  = 29;
  localparam int unsigned BIT_PERM_LINK_KILL_CORE1 = 23;
  localparam int unsigned BIT_PERM_LINK_KILL_CORE2 = 24;
  localparam int unsigned BIT_XLAT_GATE_CORE1      = 0;
  localparam int unsigned BIT_XLAT_GATE_CORE2      = 1;

  // Status layout: four enables per core, then per-core all-off flags
  localparam int unsigned STAT_LANES_PER_CORE = 4;
  localparam int unsigned STAT_OFF_BASE       = 8;

  // Cycles the dynamic link branch keeps running after the core goes idle
  localparam int unsigned IDLE_HOLD_W      = 4;
  localparam logic [IDLE_HOLD_W-1:0] IDLE_HOLD_CYCLES = 4'h8;
  localparam logic [IDLE_HOLD_W-1:0] IDLE_HOLD_ZERO   = 4'h0;
  localparam logic [IDLE_HOLD_W-1:0] IDLE_HOLD_STEP   = 4'h1;

endpackage

// >>> rtl/ppcg_core_gate.sv
// Per-core branch enable generator for transmit and link clock branches
`timescale 1ns/1ps
module ppcg_core_gate (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Gate bits from the register file
  input  wire logic tx_gate,
  input  wire logic link_dyn_gate,
  input  wire logic perm_link_kill,
  // Core activity, same clock domain
  input  wire logic core_busy,
  // Branch enables, all registered
  output logic      tx_perm_en,
  output logic      tx_dyn_en,
  output logic      link_dyn_en,
  output logic      link_perm_en,
  output logic      core_clocks_off
);

  logic [ppcg_pkg::IDLE_HOLD_W-1:0] idle_hold;
  logic [ppcg_pkg::IDLE_HOLD_W-1:0] next_idle_hold;
  logic                             next_tx_perm_en;
  logic                             next_tx_dyn_en;
  logic                             next_link_dyn_en;
  logic                             next_link_perm_en;
  logic                             next_core_clocks_off;

  // Branch enables from gate bits and activity
  always_comb begin
    next_idle_hold = idle_hold;
    if (core_busy) begin
      next_idle_hold = ppcg_pkg::IDLE_HOLD_CYCLES;
    end else if (idle_hold != ppcg_pkg::IDLE_HOLD_ZERO) begin
      next_idle_hold = idle_hold - ppcg_pkg::IDLE_HOLD_STEP;
    end
    next_tx_perm_en      = !tx_gate;
    next_tx_dyn_en       = !tx_gate && core_busy;
    next_link_dyn_en     = !link_dyn_gate && (core_busy ||
                           idle_hold != ppcg_pkg::IDLE_HOLD_ZERO);
    next_link_perm_en    = !perm_link_kill;
    next_core_clocks_off = tx_gate && link_dyn_gate && perm_link_kill;
  end

  // Enable registers; zero gate bits leave branches running
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      idle_hold       <= ppcg_pkg::IDLE_HOLD_ZERO;
      tx_perm_en      <= 1'b1;
      tx_dyn_en       <= 1'b0;
      link_dyn_en     <= 1'b0;
      link_perm_en    <= 1'b1;
      core_clocks_off <= 1'b0;
    end else begin
      idle_hold       <= next_idle_hold;
      tx_perm_en      <= next_tx_perm_en;
      tx_dyn_en       <= next_tx_dyn_en;
      link_dyn_en     <= next_link_dyn_en;
      link_perm_en    <= next_link_perm_en;
      core_clocks_off <= next_core_clocks_off;
    end
  end

endmodule

// >>> rtl/ppcg_port_guard.sv
// Drops port register accesses to a core whose clocks are off
`timescale 1ns/1ps
module ppcg_port_guard (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Core state
  input  wire logic core_clocks_off,
  // Port register access pulse in, outcome pulses out
  input  wire logic port_req,
  output logic      port_req_ok,
  output logic      port_req_dropped
);

  logic next_port_req_ok;
  logic next_port_req_dropped;

  // Pass or drop each access
  always_comb begin
    next_port_req_ok      = port_req && !core_clocks_off;
    next_port_req_dropped = port_req && core_clocks_off;
  end

  // Outcome registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      port_req_ok      <= 1'b0;
      port_req_dropped <= 1'b0;
    end else begin
      port_req_ok      <= next_port_req_ok;
      port_req_dropped <= next_port_req_dropped;
    end
  end

endmodule

// >>> rtl/ppcg_top.sv
// Top of port core clock gating: gate registers, branch enables, port guard
//
// Contract
// - Power-down bit 0 set stops core 1 transmit clock branches.
// - Spare control bit 28 set stops core 1 dynamic link branch.
// - Force bit 23 set kills core 1 permanent link branch.
// - Power-down bit 1 set stops core 2 transmit clock branches.
// - Spare control bit 29 set stops core 2 dynamic link branch.
// - Force bit 24 set kills core 2 permanent link branch.
// - Each core has running and gated transmit and link branches; its two transmit branches share one stop bit.
// - Port accesses to a gated core have no effect; restore gates last. The guard drops them only while all three stop bits of the core are set.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module ppcg_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Core activity, same clock domain
  input  wire logic [1:0]  core_busy,
  // Port register accesses per core
  input  wire logic [1:0]  port_req,
  output logic      [1:0]  port_req_ok,
  output logic      [1:0]  port_req_dropped,
  // Clock branch enables per core
  output logic      [1:0]  tx_perm_en,
  output logic      [1:0]  tx_dyn_en,
  output logic      [1:0]  link_dyn_en,
  output logic      [1:0]  link_perm_en,
  // Translation unit gate per core
  output logic      [1:0]  xlat_core_gate
);

  localparam int unsigned NC = ppcg_pkg::NUM_CORES;

  // Address match, used by write and read decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // Gate bit lookup per core index
  function automatic int unsigned tx_bit(input int unsigned c);
    tx_bit = (c == 0) ? ppcg_pkg::BIT_TX_GATE_CORE1 : ppcg_pkg::BIT_TX_GATE_CORE2;
  endfunction

  function automatic int unsigned dyn_bit(input int unsigned c);
    dyn_bit = (c == 0) ? ppcg_pkg::BIT_LINK_DYN_GATE_CORE1
                       : ppcg_pkg::BIT_LINK_DYN_GATE_CORE2;
  endfunction

  function automatic int unsigned perm_bit(input int unsigned c);
    perm_bit = (c == 0) ? ppcg_pkg::BIT_PERM_LINK_KILL_CORE1
                        : ppcg_pkg::BIT_PERM_LINK_KILL_CORE2;
  endfunction

  function automatic int unsigned xlat_bit(input int unsigned c);
    xlat_bit = (c == 0) ? ppcg_pkg::BIT_XLAT_GATE_CORE1 : ppcg_pkg::BIT_XLAT_GATE_CORE2;
  endfunction

  // Software-visible gate registers
  logic [31:0] power_down_clock_ctl;
  logic [31:0] misc_clock_force_ctl;
  logic [31:0] translation_debug_ctl_2;
  logic [31:0] clock_spare_ctl_a;
  logic [31:0] next_power_down_clock_ctl;
  logic [31:0] next_misc_clock_force_ctl;
  logic [31:0] next_translation_debug_ctl_2;
  logic [31:0] next_clock_spare_ctl_a;

  // Read path
  logic [31:0] next_reg_rdata;
  logic [31:0] branch_status;

  // Translation unit gates
  logic [1:0]  next_xlat_core_gate;

  // Per-core decoded gate bits and core state
  logic [NC-1:0] tx_gate;
  logic [NC-1:0] link_dyn_gate;
  logic [NC-1:0] perm_link_kill;
  logic [NC-1:0] core_clocks_off;

  // Register writes; full words stored, gate bits feed the cores
  always_comb begin
    next_power_down_clock_ctl    = power_down_clock_ctl;
    next_misc_clock_force_ctl    = misc_clock_force_ctl;
    next_translation_debug_ctl_2 = translation_debug_ctl_2;
    next_clock_spare_ctl_a       = clock_spare_ctl_a;
    if (reg_wr) begin
      if (addr_is(reg_addr, ppcg_pkg::OFS_POWER_DOWN_CLOCK_CTL)) begin
        next_power_down_clock_ctl = reg_wdata;
      end
      if (addr_is(reg_addr, ppcg_pkg::OFS_MISC_CLOCK_FORCE_CTL)) begin
        next_misc_clock_force_ctl = reg_wdata;
      end
      if (addr_is(reg_addr, ppcg_pkg::OFS_TRANSLATION_DEBUG_CTL_2)) begin
        next_translation_debug_ctl_2 = reg_wdata;
      end
      if (addr_is(reg_addr, ppcg_pkg::OFS_CLOCK_SPARE_CTL_A)) begin
        next_clock_spare_ctl_a = reg_wdata;
      end
    end
  end

  // Gate register storage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_down_clock_ctl    <= ppcg_pkg::RST_POWER_DOWN_CLOCK_CTL;
      misc_clock_force_ctl    <= ppcg_pkg::RST_MISC_CLOCK_FORCE_CTL;
      translation_debug_ctl_2 <= ppcg_pkg::RST_TRANSLATION_DEBUG_CTL_2;
      clock_spare_ctl_a       <= ppcg_pkg::RST_CLOCK_SPARE_CTL_A;
    end else begin
      power_down_clock_ctl    <= next_power_down_clock_ctl;
      misc_clock_force_ctl    <= next_misc_clock_force_ctl;
      translation_debug_ctl_2 <= next_translation_debug_ctl_2;
      clock_spare_ctl_a       <= next_clock_spare_ctl_a;
    end
  end

  // Per-core gating: decode bits, build enables, guard port accesses
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_core
      // Core 1 uses bits 0/28/23, core 2 bits 1/29/24
      assign tx_gate[c]        = power_down_clock_ctl[tx_bit(c)];
      assign link_dyn_gate[c]  = clock_spare_ctl_a[dyn_bit(c)];
      assign perm_link_kill[c] = misc_clock_force_ctl[perm_bit(c)];

      ppcg_core_gate u_gate (
        .clock           (clock),
        .rst_b           (rst_b),
        .tx_gate         (tx_gate[c]),
        .link_dyn_gate   (link_dyn_gate[c]),
        .perm_link_kill  (perm_link_kill[c]),
        .core_busy       (core_busy[c]),
        .tx_perm_en      (tx_perm_en[c]),
        .tx_dyn_en       (tx_dyn_en[c]),
        .link_dyn_en     (link_dyn_en[c]),
        .link_perm_en    (link_perm_en[c]),
        .core_clocks_off (core_clocks_off[c])
      );

      ppcg_port_guard u_guard (
        .clock            (clock),
        .rst_b            (rst_b),
        .core_clocks_off  (core_clocks_off[c]),
        .port_req         (port_req[c]),
        .port_req_ok      (port_req_ok[c]),
        .port_req_dropped (port_req_dropped[c])
      );

      // Status lanes: tx perm, tx dyn, link dyn, link perm, then all-off flag
      assign branch_status[c*ppcg_pkg::STAT_LANES_PER_CORE +: ppcg_pkg::STAT_LANES_PER_CORE] =
        {link_perm_en[c], link_dyn_en[c], tx_dyn_en[c], tx_perm_en[c]};
      assign branch_status[ppcg_pkg::STAT_OFF_BASE + c] = core_clocks_off[c];
    end
  endgenerate

  // Unused status bits read as zero
  assign branch_status[31:ppcg_pkg::STAT_OFF_BASE+NC] = '0;

  // Translation unit gate follows its debug bits
  always_comb begin
    next_xlat_core_gate = 2'h0;
    for (int unsigned k = 0; k < NC; k++) begin
      next_xlat_core_gate[k] = translation_debug_ctl_2[xlat_bit(k)];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_reg_rdata = ppcg_pkg::RDATA_UNMAPPED;
    if (reg_rd) begin
      if (addr_is(reg_addr, ppcg_pkg::OFS_POWER_DOWN_CLOCK_CTL)) begin
        next_reg_rdata = power_down_clock_ctl;
      end else if (addr_is(reg_addr, ppcg_pkg::OFS_MISC_CLOCK_FORCE_CTL)) begin
        next_reg_rdata = misc_clock_force_ctl;
      end else if (addr_is(reg_addr, ppcg_pkg::OFS_TRANSLATION_DEBUG_CTL_2)) begin
        next_reg_rdata = translation_debug_ctl_2;
      end else if (addr_is(reg_addr, ppcg_pkg::OFS_CLOCK_SPARE_CTL_A)) begin
        next_reg_rdata = clock_spare_ctl_a;
      end else if (addr_is(reg_addr, ppcg_pkg::OFS_BRANCH_STATUS)) begin
        next_reg_rdata = branch_status;
      end
    end
  end

  // Read data and translation gate registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata      <= ppcg_pkg::RDATA_UNMAPPED;
      xlat_core_gate <= 2'h0;
    end else begin
      reg_rdata      <= next_reg_rdata;
      xlat_core_gate <= next_xlat_core_gate;
    end
  end

endmodule

// >>> sim/ppcg_checker.sv
// Assertion checker for the port core clock gating top
`timescale 1ns/1ps
module ppcg_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Core side
  input wire logic [1:0]  core_busy,
  input wire logic [1:0]  port_req,
  input wire logic [1:0]  port_req_ok,
  input wire logic [1:0]  port_req_dropped,
  input wire logic [1:0]  tx_perm_en,
  input wire logic [1:0]  tx_dyn_en,
  input wire logic [1:0]  link_dyn_en,
  input wire logic [1:0]  link_perm_en,
  input wire logic [1:0]  xlat_core_gate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Write to one offset, then a quiet cycle for the enable to settle
  sequence s_wr_settle(logic [7:0] a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  // Gate bits drive branch enables two edges after the strobe
  a_tx_core1_gate: assert property (s_wr_settle(8'h07) |=> tx_perm_en[0] == !$past(reg_wdata[0], 2))
    else $error("core 1 transmit branch mismatch");
  a_tx_core2_gate: assert property (s_wr_settle(8'h07) |=> tx_perm_en[1] == !$past(reg_wdata[1], 2))
    else $error("core 2 transmit branch mismatch");
  a_perm_core1_kill: assert property (s_wr_settle(8'h27) |=> link_perm_en[0] == !$past(reg_wdata[23], 2))
    else $error("core 1 permanent link branch mismatch");
  a_perm_core2_kill: assert property (s_wr_settle(8'h27) |=> link_perm_en[1] == !$past(reg_wdata[24], 2))
    else $error("core 2 permanent link branch mismatch");
  a_xlat_gate_copy: assert property (s_wr_settle(8'h46) |=> xlat_core_gate == $past(reg_wdata[1:0], 2))
    else $error("translation gate copy mismatch");
  a_dyn_link_stop: assert property (s_wr_settle(8'he0) ##0 $past(reg_wdata[28]) |=> !link_dyn_en[0])
    else $error("core 1 dynamic link branch still running");
  a_dyn_core2_stop: assert property (s_wr_settle(8'he0) ##0 $past(reg_wdata[29]) |=> !link_dyn_en[1])
    else $error("core 2 dynamic link branch still running");
  a_tx_dyn_nested: assert property (tx_dyn_en[0] |-> tx_perm_en[0] && $past(core_busy[0]))
    else $error("dynamic transmit branch without cause");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_port_one_outcome: assert property (port_req[0] |=> port_req_ok[0] ^ port_req_dropped[0])
    else $error("port access outcome missing");
endmodule
bind ppcg_top ppcg_checker u_chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_busy(core_busy), .port_req(port_req), .port_req_ok(port_req_ok),
  .port_req_dropped(port_req_dropped), .tx_perm_en(tx_perm_en), .tx_dyn_en(tx_dyn_en),
  .link_dyn_en(link_dyn_en), .link_perm_en(link_perm_en), .xlat_core_gate(xlat_core_gate));

// >>> sim/tb_top.sv
// Self-checking testbench for the port core clock gating top
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0]  core_busy = 2'h0;
  logic [1:0]  port_req = 2'h0;
  logic [1:0]  port_req_ok, port_req_dropped;
  logic [1:0]  tx_perm_en, tx_dyn_en, link_dyn_en, link_perm_en, xlat_core_gate;
  int          failures = 0;
  int          samples_checked = 0;
  logic [7:0]  adr [4] = '{8'h07, 8'he0, 8'h27, 8'h46};
  int          bitp [4] = '{0, 28, 23, 0};
  logic [1:0]  m;
  ppcg_top uut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_busy(core_busy),
    .port_req(port_req), .port_req_ok(port_req_ok), .port_req_dropped(port_req_dropped),
    .tx_perm_en(tx_perm_en), .tx_dyn_en(tx_dyn_en), .link_dyn_en(link_dyn_en),
    .link_perm_en(link_perm_en), .xlat_core_gate(xlat_core_gate));
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read strobe, data checked mid-cycle after the strobe drops
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check(reg_rdata, exp);
  endtask
  // Port access pulse, outcome checked one cycle later
  task automatic port(input logic [1:0] ok);
    @(posedge clock);
    port_req <= 2'h3;
    @(posedge clock);
    port_req <= 2'h0;
    @(negedge clock);
    check({port_req_ok, port_req_dropped}, {ok, ~ok});
  endtask
  // Packs all enables for one compare
  function automatic logic [31:0] en_vec();
    return {22'h0, tx_perm_en, tx_dyn_en, link_dyn_en, link_perm_en, xlat_core_gate};
  endfunction
  task automatic end_of_test();
    $display("checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    // Reset values, unmapped and status reads
    for (int k = 0; k < 4; k++) rd(adr[k], 32'h0000_0000);
    rd(8'h55, 32'h0000_0000);
    wr(8'h55, 32'hffff_ffff);
    rd(8'h55, 32'h0000_0000);
    rd(8'hf0, 32'h0000_0099);
    check(en_vec(), 32'h0000_030c);
    $display("test done: reset values");
    // Gate each core one bit at a time
    core_busy <= 2'h3;
    for (int c = 0; c < 2; c++) begin
      m = 2'h1 << c;
      for (int k = 0; k < 4; k++) begin
        wr(adr[k], 32'h1 << (bitp[k] + c));
        repeat (3) @(posedge clock);
        check(en_vec(), {22'h0, ~m, ~m, (k > 0) ? ~m : 2'h3, (k > 1) ? ~m : 2'h3,
                         (k > 2) ? m : 2'h0});
        port((k > 1) ? ~m : 2'h3);
        rd(adr[k], 32'h1 << (bitp[k] + c));
      end
      rd(8'hf0, (c == 0) ? 32'h0000_01f0 : 32'h0000_020f);
      for (int k = 0; k < 4; k++) wr(adr[k], 32'h0000_0000);
      repeat (3) @(posedge clock);
      check(en_vec(), 32'h0000_03fc);
      port(2'h3);
    end
    $display("test done: per core gating");
    // Dynamic link branch idle hold after activity stops
    @(posedge clock);
    core_busy <= 2'h0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check({30'h0, link_dyn_en}, 32'h3);
    @(negedge clock);
    check({28'h0, tx_dyn_en, link_dyn_en}, 32'h0);
    $display("test done: idle hold");
    // Reset in mid-run clears gate registers
    wr(8'h07, 32'h0000_0003);
    repeat (3) @(posedge clock);
    check({30'h0, tx_perm_en}, 32'h0);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h07, 32'h0000_0000);
    check({30'h0, tx_perm_en}, 32'h3);
    $display("test done: mid-run reset");
    end_of_test();
  end
endmodule
